// [verilog/tps_pkg.sv]
/*
 * Shared constants for the panel sync timing block: register map,
 * field layout, reset values, state codes and fixed timing figures.
 * Assumes a word-addressed plain register port and one system clock.
 */
`default_nettype none
package tps_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int PIX_W = 16;
    localparam int CNT_W = 10;
    localparam int FLD_W = 8;
    localparam int DIV_W = 6;

    typedef logic [CNT_W-1:0] tps_cnt_t;
    typedef logic [DIV_W-1:0] tps_div_t;
    typedef logic [DATA_W-1:0] tps_word_t;

    // register indexes on the word-addressed port
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_HTIME = 4'h1;
    localparam logic [ADDR_W-1:0] REG_VTIME = 4'h2;
    localparam logic [ADDR_W-1:0] REG_SIZE = 4'h3;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;

    // control bits; a set polarity bit makes that output active low
    localparam int CTRL_EN = 0;
    localparam int CTRL_VS_POL = 1;
    localparam int CTRL_HS_POL = 2;
    localparam int CTRL_DE_POL = 3;
    localparam int CTRL_CLK_POL = 4;
    localparam int CTRL_DATA_POL = 5;
    localparam int CTRL_GATE_VS = 6;
    localparam int CTRL_GATE_DE = 7;
    localparam int CTRL_VARIANT = 8;
    localparam int CTRL_DIV_LSB = 16;

    // field positions
    localparam int HT_HSYNC_LSB = 0;
    localparam int HT_END_LSB = 8;
    localparam int HT_START_LSB = 16;
    localparam int VT_VSYNC_LSB = 0;
    localparam int VT_END_LSB = 8;
    localparam int VT_START_LSB = 16;
    localparam int SZ_WIDTH_LSB = 0;
    localparam int SZ_ROWS_LSB = 16;
    localparam int ST_V_LSB = 0;
    localparam int ST_H_LSB = 4;
    localparam int ST_LINE_LSB = 16;

    // writable bits; reserved bits read as zero
    localparam tps_word_t CTRL_MASK = 32'h003f_01ff;
    localparam tps_word_t HTIME_MASK = 32'h00ff_ffff;
    localparam tps_word_t VTIME_MASK = 32'h00ff_ffff;
    localparam tps_word_t SIZE_MASK = 32'h03ff_03ff;

    localparam tps_word_t CTRL_RST = 32'h0000_0000;
    localparam tps_word_t HTIME_RST = 32'h0000_0000;
    localparam tps_word_t VTIME_RST = 32'h0000_0001;
    localparam tps_word_t SIZE_RST = 32'h00f0_0140;

    // idle and enable-delay lengths in pixel clock periods
    localparam tps_cnt_t IDLE_BLANK_TS = 10'h002;
    localparam tps_cnt_t IDLE_DISP_TS = 10'h001;
    localparam tps_cnt_t DE_DLY_STD_TS = 10'h001;
    localparam tps_cnt_t DE_DLY_VAR_TS = 10'h002;
    localparam tps_cnt_t CNT_ONE = 10'h001;
    localparam tps_cnt_t CNT_ZERO = 10'h000;

    typedef enum logic [2:0] {
        H_SYNC = 3'h0,
        H_START = 3'h1,
        H_IDLE = 3'h2,
        H_DELAY = 3'h3,
        H_DATA = 3'h4,
        H_END = 3'h5
    } tps_hstate_t;

    typedef enum logic [1:0] {
        V_PULSE = 2'h0,
        V_BACK = 2'h1,
        V_DISP = 2'h2,
        V_FRONT = 2'h3
    } tps_vstate_t;

    // last count index for a length of n, a zero length acting as one
    function automatic tps_cnt_t lim_m1(input tps_cnt_t n);
        lim_m1 = (n == CNT_ZERO) ? CNT_ZERO : n - CNT_ONE;
    endfunction : lim_m1
endpackage : tps_pkg
`default_nettype wire

// [verilog/tps_pixclk_div.sv]
/*
 * Pixel clock divider: one-cycle step pulse every div+1 system clocks
 * and a half-period level for the panel clock pin.
 * Assumes div is quasi-static; a smaller new value takes effect at once.
 */
`timescale 1ns/1ps
`default_nettype none
module tps_pixclk_div (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // divider setting and outputs
    input wire tps_pkg::tps_div_t div,
    output logic tick,
    output logic phase_hi
);
    tps_pkg::tps_div_t cnt;

    // >= so that shrinking div never strands the counter
    assign tick = (cnt >= div);
    // div of zero gives no visible clock edge, only a step every cycle
    assign phase_hi = (cnt <= (div >> 1));

    always_ff @(posedge clk) begin
        if (reset || tick) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + tps_pkg::tps_div_t'(1);
        end
    end
endmodule : tps_pixclk_div
`default_nettype wire

// [verilog/tps_out_stage.sv]
/*
 * Panel output stage: applies polarity, gates nothing itself, and
 * registers every panel pin plus the pixel-taken pulse.
 * Assumes active-high inputs from the timing logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tps_out_stage (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // active-high levels
    input wire logic vs_act,
    input wire logic hs_act,
    input wire logic de_act,
    input wire logic clk_lvl,
    input wire logic take,
    input wire logic [tps_pkg::PIX_W-1:0] pix_in,
    // polarity selects
    input wire logic vs_pol,
    input wire logic hs_pol,
    input wire logic de_pol,
    input wire logic clk_pol,
    input wire logic data_pol,
    // panel side
    output logic vsync,
    output logic hsync,
    output logic de,
    output logic pclk,
    output logic [tps_pkg::PIX_W-1:0] data,
    output logic pix_next
);
    logic [tps_pkg::PIX_W-1:0] pix;
    wire logic [tps_pkg::PIX_W-1:0] pix_sel;

    // data parks at zero (all ones when data_pol is set) outside the enable so blanking is clean
    assign pix_sel = take ? pix_in : (de_act ? pix : '0);

    always_ff @(posedge clk) begin
        if (reset) begin
            vsync <= 1'b0;
            hsync <= 1'b0;
            de <= 1'b0;
            pclk <= 1'b0;
            data <= '0;
            pix <= '0;
            pix_next <= 1'b0;
        end else begin
            vsync <= vs_act ^ vs_pol;
            hsync <= hs_act ^ hs_pol;
            de <= de_act ^ de_pol;
            pclk <= clk_lvl ^ clk_pol;
            data <= pix_sel ^ {tps_pkg::PIX_W{data_pol}};
            pix <= pix_sel;
            pix_next <= take;
        end
    end
endmodule : tps_out_stage
`default_nettype wire

// [verilog/tps_top.sv]
/*
 * TFT panel sync timing generator: line and frame sequencers, register
 * port, pixel clock divider and registered panel outputs.
 * Assumes pixel words on PIXEL_IN are ready before each PIXEL_NEXT.
 */
// Overview of operation
// - pixel period is source clock times divider plus one; all counts use it
// - horizontal sync lasts hsync_pulse_len plus one pixel periods
// - after horizontal sync wait line_start_wait plus one periods, then idle
// - after data enable ends wait line_end_wait plus one before next sync
// - line period is width plus sync, both waits, idle and enable delay
// - idle before vertical edge is two periods blanking, one in display
// - enable follows vertical sync by one period, two with variant bit
// - vertical sync starts frame_end_wait lines after last enable plus overhead
// - vertical pulse lasts vsync_pulse_lines lines; start wait frame_start_wait
// - vertical, horizontal and enable polarity each selectable by software
// - pixel clock and pixel data bus polarity can be inverted
// - pixel clock optionally stopped in vertical pulse or while enable low
`timescale 1ns/1ps
`default_nettype none
module tps_top (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    // register port
    input wire logic [tps_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [tps_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [tps_pkg::DATA_W-1:0] REG_RDATA,
    // pixel source
    input wire logic [tps_pkg::PIX_W-1:0] PIXEL_IN,
    output logic PIXEL_NEXT,
    // panel pins
    output logic PANEL_VSYNC,
    output logic PANEL_HSYNC,
    output logic PANEL_DE,
    output logic PANEL_CLK,
    output logic [tps_pkg::PIX_W-1:0] PANEL_DATA
);
    tps_pkg::tps_word_t ctrl;
    tps_pkg::tps_word_t htime;
    tps_pkg::tps_word_t vtime;
    tps_pkg::tps_word_t size;
    tps_pkg::tps_hstate_t hstate;
    tps_pkg::tps_hstate_t next_hstate;
    tps_pkg::tps_vstate_t vstate;
    tps_pkg::tps_vstate_t next_vstate;
    tps_pkg::tps_cnt_t h_cnt;
    tps_pkg::tps_cnt_t h_lim;
    tps_pkg::tps_cnt_t v_cnt;
    tps_pkg::tps_cnt_t v_lim;
    logic tick;
    logic phase_hi;

    // field decode
    wire logic run = ctrl[tps_pkg::CTRL_EN];
    wire logic variant = ctrl[tps_pkg::CTRL_VARIANT];
    wire logic gate_vs = ctrl[tps_pkg::CTRL_GATE_VS];
    wire logic gate_de = ctrl[tps_pkg::CTRL_GATE_DE];
    wire logic clk_pol = ctrl[tps_pkg::CTRL_CLK_POL];
    wire logic de_pol = ctrl[tps_pkg::CTRL_DE_POL];
    wire tps_pkg::tps_div_t pix_div =
        ctrl[tps_pkg::CTRL_DIV_LSB +: tps_pkg::DIV_W];
    wire tps_pkg::tps_cnt_t hs_len = tps_pkg::tps_cnt_t'(
        htime[tps_pkg::HT_HSYNC_LSB +: tps_pkg::FLD_W]);
    wire tps_pkg::tps_cnt_t end_wait = tps_pkg::tps_cnt_t'(
        htime[tps_pkg::HT_END_LSB +: tps_pkg::FLD_W]);
    wire tps_pkg::tps_cnt_t start_wait = tps_pkg::tps_cnt_t'(
        htime[tps_pkg::HT_START_LSB +: tps_pkg::FLD_W]);
    wire tps_pkg::tps_cnt_t vs_lines = tps_pkg::tps_cnt_t'(
        vtime[tps_pkg::VT_VSYNC_LSB +: tps_pkg::FLD_W]);
    wire tps_pkg::tps_cnt_t fr_end = tps_pkg::tps_cnt_t'(
        vtime[tps_pkg::VT_END_LSB +: tps_pkg::FLD_W]);
    wire tps_pkg::tps_cnt_t fr_start = tps_pkg::tps_cnt_t'(
        vtime[tps_pkg::VT_START_LSB +: tps_pkg::FLD_W]);
    wire tps_pkg::tps_cnt_t width = size[tps_pkg::SZ_WIDTH_LSB +: tps_pkg::CNT_W];
    wire tps_pkg::tps_cnt_t rows = size[tps_pkg::SZ_ROWS_LSB +: tps_pkg::CNT_W];

    // register port decode
    wire logic wr_ctrl = REG_WR && (REG_ADDR == tps_pkg::REG_CTRL);
    wire logic wr_htime = REG_WR && (REG_ADDR == tps_pkg::REG_HTIME);
    wire logic wr_vtime = REG_WR && (REG_ADDR == tps_pkg::REG_VTIME);
    wire logic wr_size = REG_WR && (REG_ADDR == tps_pkg::REG_SIZE);
    wire tps_pkg::tps_word_t status =
        (tps_pkg::tps_word_t'(vstate) << tps_pkg::ST_V_LSB) |
        (tps_pkg::tps_word_t'(hstate) << tps_pkg::ST_H_LSB) |
        (tps_pkg::tps_word_t'(v_cnt) << tps_pkg::ST_LINE_LSB);
    tps_pkg::tps_word_t rd_mux;

    always_comb begin
        if (REG_ADDR == tps_pkg::REG_CTRL) begin
            rd_mux = ctrl & tps_pkg::CTRL_MASK;
        end else if (REG_ADDR == tps_pkg::REG_HTIME) begin
            rd_mux = htime & tps_pkg::HTIME_MASK;
        end else if (REG_ADDR == tps_pkg::REG_VTIME) begin
            rd_mux = vtime & tps_pkg::VTIME_MASK;
        end else if (REG_ADDR == tps_pkg::REG_SIZE) begin
            rd_mux = size & tps_pkg::SIZE_MASK;
        end else if (REG_ADDR == tps_pkg::REG_STATUS) begin
            rd_mux = status;
        end else begin
            rd_mux = '0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            ctrl <= tps_pkg::CTRL_RST;
            htime <= tps_pkg::HTIME_RST;
            vtime <= tps_pkg::VTIME_RST;
            size <= tps_pkg::SIZE_RST;
            REG_RDATA <= '0;
        end else begin
            if (wr_ctrl) ctrl <= REG_WDATA & tps_pkg::CTRL_MASK;
            if (wr_htime) htime <= REG_WDATA & tps_pkg::HTIME_MASK;
            if (wr_vtime) vtime <= REG_WDATA & tps_pkg::VTIME_MASK;
            if (wr_size) size <= REG_WDATA & tps_pkg::SIZE_MASK;
            REG_RDATA <= REG_RD ? rd_mux : '0;
        end
    end

    tps_pixclk_div u_div (
        .clk(SYS_CLK),
        .reset(RESET),
        .div(pix_div),
        .tick(tick),
        .phase_hi(phase_hi)
    );

    // everything below advances once per pixel period
    wire logic step = tick && run;
    wire logic disp = (vstate == tps_pkg::V_DISP);

    // line sequencer; phase lengths sum to one full line
    always_comb begin
        next_hstate = hstate;
        h_lim = tps_pkg::CNT_ZERO;
        case (hstate)
            tps_pkg::H_SYNC: begin
                h_lim = hs_len;
                next_hstate = tps_pkg::H_START;
            end
            tps_pkg::H_START: begin
                h_lim = start_wait;
                next_hstate = tps_pkg::H_IDLE;
            end
            tps_pkg::H_IDLE: begin
                h_lim = tps_pkg::lim_m1(disp ? tps_pkg::IDLE_DISP_TS
                                             : tps_pkg::IDLE_BLANK_TS);
                next_hstate = tps_pkg::H_DELAY;
            end
            tps_pkg::H_DELAY: begin
                h_lim = tps_pkg::lim_m1(variant ? tps_pkg::DE_DLY_VAR_TS
                                                : tps_pkg::DE_DLY_STD_TS);
                next_hstate = tps_pkg::H_DATA;
            end
            tps_pkg::H_DATA: begin
                h_lim = tps_pkg::lim_m1(width);
                next_hstate = tps_pkg::H_END;
            end
            tps_pkg::H_END: begin
                h_lim = end_wait;
                next_hstate = tps_pkg::H_SYNC;
            end
            default: begin
                h_lim = tps_pkg::CNT_ZERO;
                next_hstate = tps_pkg::H_SYNC;
            end
        endcase
    end

    // >= keeps a mid-phase register change from stalling the line
    wire logic h_adv = step && (h_cnt >= h_lim);
    // vertical edges sit at the end of the idle phase
    wire logic line_mark = h_adv && (hstate == tps_pkg::H_IDLE);

    always_ff @(posedge SYS_CLK) begin
        if (RESET || !run) begin
            hstate <= tps_pkg::H_SYNC;
            h_cnt <= tps_pkg::CNT_ZERO;
        end else if (h_adv) begin
            hstate <= next_hstate;
            h_cnt <= tps_pkg::CNT_ZERO;
        end else if (step) begin
            h_cnt <= h_cnt + tps_pkg::CNT_ONE;
        end
    end

    // frame sequencer, counted in whole lines
    always_comb begin
        next_vstate = vstate;
        v_lim = tps_pkg::CNT_ZERO;
        case (vstate)
            tps_pkg::V_PULSE: begin
                v_lim = tps_pkg::lim_m1(vs_lines);
                next_vstate = (fr_start == tps_pkg::CNT_ZERO) ?
                    tps_pkg::V_DISP : tps_pkg::V_BACK;
            end
            tps_pkg::V_BACK: begin
                v_lim = tps_pkg::lim_m1(fr_start);
                next_vstate = tps_pkg::V_DISP;
            end
            tps_pkg::V_DISP: begin
                v_lim = tps_pkg::lim_m1(rows);
                next_vstate = (fr_end == tps_pkg::CNT_ZERO) ?
                    tps_pkg::V_PULSE : tps_pkg::V_FRONT;
            end
            tps_pkg::V_FRONT: begin
                v_lim = tps_pkg::lim_m1(fr_end);
                next_vstate = tps_pkg::V_PULSE;
            end
            default: begin
                v_lim = tps_pkg::CNT_ZERO;
                next_vstate = tps_pkg::V_PULSE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET || !run) begin
            vstate <= tps_pkg::V_PULSE;
            v_cnt <= tps_pkg::CNT_ZERO;
        end else if (line_mark && (v_cnt >= v_lim)) begin
            vstate <= next_vstate;
            v_cnt <= tps_pkg::CNT_ZERO;
        end else if (line_mark) begin
            v_cnt <= v_cnt + tps_pkg::CNT_ONE;
        end
    end

    // active-high panel levels
    wire logic vs_act = run && (vstate == tps_pkg::V_PULSE);
    wire logic hs_act = run && (hstate == tps_pkg::H_SYNC);
    wire logic de_act = run && disp && (hstate == tps_pkg::H_DATA);
    wire logic clk_stop = !run || (gate_vs && vs_act) ||
        (gate_de && !de_act);
    wire logic take = de_act && step;

    tps_out_stage u_out (
        .clk(SYS_CLK),
        .reset(RESET),
        .vs_act(vs_act),
        .hs_act(hs_act),
        .de_act(de_act),
        .clk_lvl(phase_hi && !clk_stop),
        .take(take),
        .pix_in(PIXEL_IN),
        .vs_pol(ctrl[tps_pkg::CTRL_VS_POL]),
        .hs_pol(ctrl[tps_pkg::CTRL_HS_POL]),
        .de_pol(de_pol),
        .clk_pol(clk_pol),
        .data_pol(ctrl[tps_pkg::CTRL_DATA_POL]),
        .vsync(PANEL_VSYNC),
        .hsync(PANEL_HSYNC),
        .de(PANEL_DE),
        .pclk(PANEL_CLK),
        .data(PANEL_DATA),
        .pix_next(PIXEL_NEXT)
    );

    // checks
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    tps_pkg::tps_div_t gap;
    logic gap_clean;
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            gap <= '0;
            gap_clean <= 1'b0;
        end else begin
            gap <= tick ? '0 : gap + tps_pkg::tps_div_t'(1);
            gap_clean <= wr_ctrl ? 1'b0 : (tick ? 1'b1 : gap_clean);
        end
    end

    tick_period_a: assert property (
        tick && gap_clean |-> gap == pix_div)
        else $error("pixel step spacing differs from divider");
    hsync_len_a: assert property (
        step && hstate == tps_pkg::H_SYNC && !wr_htime |=>
        hstate == ($past(h_cnt) >= $past(hs_len) ?
                   tps_pkg::H_START : tps_pkg::H_SYNC))
        else $error("horizontal sync length wrong");
    start_wait_a: assert property (
        step && hstate == tps_pkg::H_START && h_cnt >= start_wait |=>
        hstate == tps_pkg::H_IDLE && h_cnt == tps_pkg::CNT_ZERO)
        else $error("line start wait did not end");
    end_wait_a: assert property (
        step && hstate == tps_pkg::H_END && h_cnt < end_wait |=>
        hstate == tps_pkg::H_END)
        else $error("next sync began too early");
    idle_len_a: assert property (
        step && hstate == tps_pkg::H_IDLE |=>
        (hstate == tps_pkg::H_DELAY) ==
        ($past(disp) || $past(h_cnt) != tps_pkg::CNT_ZERO))
        else $error("idle length wrong for region");
    // clearing the enable parks the frame sequencer off the line grid
    vs_edge_a: assert property (
        run && vstate != $past(vstate) |-> $past(line_mark))
        else $error("vertical edge away from idle end");
    de_delay_a: assert property (
        step && hstate == tps_pkg::H_DELAY && !variant |=>
        hstate == tps_pkg::H_DATA)
        else $error("enable delay not one period");
    de_region_a: assert property (
        PANEL_DE != $past(de_pol) |->
        $past(vstate) == tps_pkg::V_DISP && $past(hstate) == tps_pkg::H_DATA)
        else $error("enable outside display data");
    clk_gate_a: assert property (
        run && gate_vs && vstate == tps_pkg::V_PULSE |=>
        PANEL_CLK == $past(clk_pol))
        else $error("pixel clock ran in vertical pulse");
    clk_gate_de_a: assert property (
        run && gate_de && !de_act |=> PANEL_CLK == $past(clk_pol))
        else $error("pixel clock ran with enable low");
endmodule : tps_top
`default_nettype wire

// [bench/tps_panel_model.sv]
/*
 * Panel model: watches the panel pins and measures sync, enable and
 * clock timing in system clock cycles, plus the last pixel taken.
 * Assumes panel pins registered on clk; the panel knows the polarity.
 */
`timescale 1ns/1ps
`default_nettype none
module tps_panel_model (
    // clock and clear
    input wire logic clk,
    input wire logic clr,
    // panel pins
    input wire logic vsync,
    input wire logic hsync,
    input wire logic de,
    input wire logic pclk,
    input wire logic [15:0] data,
    // active-low or inverted: vs, hs, de, data
    input wire logic [3:0] pol,
    // measurements and last pixel seen
    output int m [10],
    output logic [15:0] pix
);
    int t, thr, thf, ter, tef, tvr, hc, dc;
    logic v, h, e, vd, hd, ed, cd;
    assign v = vsync ^ pol[0];
    assign h = hsync ^ pol[1];
    assign e = de ^ pol[2];
    always @(posedge clk) begin
        t <= t + 1;
        {vd, hd, ed, cd} <= {v, h, e, pclk};
        if (e)
            pix <= data ^ {16{pol[3]}};
        if (h && !hd) begin
            thr <= t;
            // blanking lines have no enable before them, so keep the least
            if (t - tef < m[2])
                m[2] <= t - tef;
            hc <= hc + 1;
        end
        if (!h && hd) begin
            thf <= t;
            m[0] <= t - thr;
        end
        if (e && !ed) begin
            ter <= t;
            dc <= dc + 1;
            if (t - thf < m[3])
                m[3] <= t - thf;
            if (t - ter < m[4])
                m[4] <= t - ter;
        end
        if (!e && ed) begin
            tef <= t;
            m[1] <= t - ter;
        end
        if (v && !vd) begin
            tvr <= t;
            {m[6], m[7], hc, dc} <= {hc, dc, 64'h0};
            m[8] <= m[8] + 1;
        end
        if (!v && vd)
            m[5] <= t - tvr;
        // clock edges while sync is active, to see gating
        if (h && hd && pclk != cd)
            m[9] <= m[9] + 1;
        // stale stamps far back so first gaps never look short
        if (clr) begin
            {t, hc, dc} <= '0;
            {thr, thf, ter, tef, tvr} <= {5{-32'sd99999}};
            m <= '{2: 99999, 3: 99999, 4: 99999, default: 0};
            pix <= 16'h0000;
        end
    end
endmodule : tps_panel_model
`default_nettype wire

// [bench/tb_tps_top.sv]
/*
 * Testbench for the panel sync timing block: register port checks,
 * then two timing setups measured by the panel model.
 * Assumes the register map and line order given by the designer.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_tps_top;
    logic SYS_CLK = 1'b0;
    logic RESET = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata, rd, ctl;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] pixel_in = 16'ha5c3;
    logic [15:0] panel_data, pix;
    logic pixel_next, panel_vsync, panel_hsync, panel_de, panel_clk;
    logic mdl_clr = 1'b1;
    logic [3:0] pol = 4'h0;
    int m [10];
    int err_total, n_compared, cycles, p, ln, n_next;
    int dv[2] = '{1, 2};
    int hs[2] = '{2, 0};
    int ls[2] = '{0, 2};
    int le[2] = '{1, 0};
    int vr[2] = '{0, 1};
    int wd[2] = '{4, 5};
    int vl[2] = '{2, 1};
    int fe[2] = '{1, 2};
    int rw[2] = '{3, 2};

    tps_top i_dut (
        .SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .PIXEL_IN(pixel_in),
        .PIXEL_NEXT(pixel_next), .PANEL_VSYNC(panel_vsync),
        .PANEL_HSYNC(panel_hsync), .PANEL_DE(panel_de),
        .PANEL_CLK(panel_clk), .PANEL_DATA(panel_data)
    );
    tps_panel_model i_panel (
        .clk(SYS_CLK), .clr(mdl_clr), .vsync(panel_vsync),
        .hsync(panel_hsync), .de(panel_de), .pclk(panel_clk),
        .data(panel_data), .pol(pol), .m(m), .pix(pix)
    );

    always #5 SYS_CLK = ~SYS_CLK;

    // pixel words taken since the model was last cleared
    always @(posedge SYS_CLK) begin
        if (mdl_clr)
            n_next <= 0;
        else if (pixel_next)
            n_next <= n_next + 1;
    end

    // hang guard: the two setups need well under 3000 cycles
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    task automatic chk_w(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_w

    task automatic chk_i(input string what, input int exp, input int got);
        n_compared++;
        if (got != exp) begin
            err_total++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_i

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge SYS_CLK);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge SYS_CLK);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge SYS_CLK);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    initial begin
        repeat (4) @(posedge SYS_CLK);
        RESET <= 1'b0;
        // reset values, then unmapped and reserved places read zero
        reg_read(tps_pkg::REG_CTRL, rd);
        chk_w("ctrl reset", tps_pkg::CTRL_RST, rd);
        reg_read(tps_pkg::REG_VTIME, rd);
        chk_w("vtime reset", tps_pkg::VTIME_RST, rd);
        reg_read(tps_pkg::REG_SIZE, rd);
        chk_w("size reset", tps_pkg::SIZE_RST, rd);
        reg_write(4'h9, 32'hffff_ffff);
        reg_read(4'h9, rd);
        chk_w("unmapped", 32'h0, rd);
        reg_write(tps_pkg::REG_HTIME, 32'hffff_ffff);
        reg_read(tps_pkg::REG_HTIME, rd);
        chk_w("htime reserved", 32'h00ff_ffff, rd);
        for (int c = 0; c < 2; c++) begin
            p = dv[c] + 1;
            ln = hs[c] + ls[c] + le[c] + vr[c] + wd[c] + 5;
            pol <= {4{c[0]}};
            // second setup: all inverted, clock stopped in vsync, off enable
            ctl = 32'(dv[c] << 16) | 32'(vr[c] << 8) | (c ? 32'hfe : 32'h0);
            reg_write(tps_pkg::REG_CTRL, ctl);
            repeat (3) @(posedge SYS_CLK);
            chk_w("idle sync", {3{c[0]}},
                  {panel_vsync, panel_hsync, panel_de});
            chk_w("idle data", {16{c[0]}}, panel_data);
            reg_read(tps_pkg::REG_STATUS, rd);
            chk_w("status idle", 32'h0, rd);
            reg_write(tps_pkg::REG_HTIME, 32'(ls[c] << 16 | le[c] << 8 | hs[c]));
            reg_write(tps_pkg::REG_VTIME, 32'(1 << 16 | fe[c] << 8 | vl[c]));
            reg_write(tps_pkg::REG_SIZE, 32'(rw[c] << 16 | wd[c]));
            reg_write(tps_pkg::REG_CTRL, ctl | 32'h1);
            mdl_clr <= 1'b1;
            @(posedge SYS_CLK);
            mdl_clr <= 1'b0;
            // let the clear land before the frame count is looked at
            @(posedge SYS_CLK);
            while (m[8] < 3)
                @(posedge SYS_CLK);
            chk_i("hsync width", (hs[c] + 1) * p, m[0]);
            chk_i("enable width", wd[c] * p, m[1]);
            chk_i("enable to hsync", (le[c] + 1) * p, m[2]);
            chk_i("hsync to enable", (ls[c] + 3 + vr[c]) * p, m[3]);
            chk_i("line period", ln * p, m[4]);
            chk_i("vsync width", vl[c] * (ln + 1) * p, m[5]);
            chk_i("lines a frame", vl[c] + 1 + rw[c] + fe[c], m[6]);
            chk_i("rows a frame", rw[c], m[7]);
            chk_i("clock runs in sync", 1 - c, int'(m[9] != 0));
            chk_w("pixel", 16'ha5c3, pix);
            chk_i("pixel takes", 2 * rw[c] * wd[c], n_next);
        end
        complete_run();
    end
endmodule : tb_tps_top
`default_nettype wire
